// ---- rtl/sprdr_top.sv ----
/*
  Interrupt, DMA pointer and buffer registers of a serial port.
  Assumes a receiver that delivers finished words with error status,
  a DMA controller that reports end of block, and an 8-bit register port.
*/
`default_nettype none
module sprdr_top
  import sprdr_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Receiver word interface
  input wire logic RX_WORD,
  input wire logic [7:0] RX_RAW,
  input wire logic [1:0] RX_WLEN,
  input wire logic RX_FRAME_ERR,
  input wire logic RX_PARITY_ERR,
  input wire logic RX_BREAK,
  // DMA controller
  input wire logic RX_DMA_EOB,
  input wire logic TX_DMA_EOB,
  output logic RX_DMA_REQ,
  output logic TX_DMA_REQ,
  // Interrupt request and serial out
  output logic IRQ,
  output logic TXD_OUT
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] rcp;
    logic [7:0] rap;
    logic [7:0] tcp;
    logic [7:0] tap;
    logic [4:0] vbase;
    logic [7:0] cmp;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] ctrl;
    logic [7:0] rxbuf;
    logic [7:0] txbuf;
    logic txfull;
    logic addressed;
    logic rxunread;
    logic [7:0] rdata;
    logic [7:0] bdiv;
  } sprdr_st_t;
  localparam logic [7:0] BIT_DIV = 8'h0F;
  sprdr_st_t s_q, s_d;
  logic [7:0] rx_word;
  logic rx_hit;
  logic sh_busy, sh_done, sh_load, bit_en;
  logic rx_err_irq, adr_irq, rx_dat_irq, tx_irq;
  logic [1:0] src;
  logic [7:0] vec_rd;
  logic wsel, rsel;
  // ****************************************
  // Submodules
  // ****************************************
  sprdr_rxfmt u_fmt (
    .raw(RX_RAW),
    .wlen(RX_WLEN),
    .cmp(s_q.cmp),
    .word(rx_word),
    .hit(rx_hit)
  );
  sprdr_txshift u_sh (
    .clk(MCLK),
    .rst_n(RST_N),
    .bit_en(bit_en),
    .load(sh_load),
    .data(s_q.txbuf),
    .busy(sh_busy),
    .done(sh_done),
    .serial(TXD_OUT)
  );
  // Bit rate enable
  assign bit_en = (s_q.bdiv == BIT_DIV);
  // Transmit buffer moves to shifter when free
  assign sh_load = s_q.txfull && !sh_busy;
  // ****************************************
  // Interrupt sources and vector code
  // ****************************************
  always_comb begin
    rx_err_irq = s_q.mask[MSK_RXERR] &&
      (s_q.flags[FLG_OVR] || s_q.flags[FLG_FRM] || s_q.flags[FLG_PAR]);
    adr_irq = (s_q.mask[MSK_ADDR] && s_q.flags[FLG_ADR]) ||
      (s_q.mask[MSK_BRK] && s_q.flags[FLG_BRK]);
    // End of block stands in for data pending while DMA runs
    if (s_q.ctrl[CTL_RXDMA]) begin
      rx_dat_irq = s_q.mask[MSK_RX_DATA_IRQ_ENABLE] && s_q.mask[MSK_RX_BLOCK_DONE];
    end else begin
      rx_dat_irq = s_q.mask[MSK_RX_DATA_IRQ_ENABLE] &&
        (s_q.flags[FLG_DAT] || s_q.mask[MSK_RX_BLOCK_DONE]);
    end
    if (s_q.ctrl[CTL_TXDMA]) begin
      tx_irq = s_q.mask[MSK_TX_DATA_IRQ_ENABLE] && s_q.mask[MSK_TX_BLOCK_DONE];
    end else if (s_q.mask[MSK_TXSRC]) begin
      tx_irq = s_q.mask[MSK_TX_DATA_IRQ_ENABLE] &&
        (s_q.flags[FLG_TBE] || s_q.mask[MSK_TX_BLOCK_DONE]);
    end else begin
      tx_irq = s_q.mask[MSK_TX_DATA_IRQ_ENABLE] &&
        (s_q.flags[FLG_TSE] || s_q.mask[MSK_TX_BLOCK_DONE]);
    end
    // Receive before transmit; errors first among receive
    if (rx_err_irq) begin
      src = SRC_RXERR;
    end else if (adr_irq) begin
      src = SRC_ADRBRK;
    end else if (rx_dat_irq) begin
      src = SRC_RXDATA;
    end else begin
      src = SRC_TXEMPTY;
    end
    vec_rd = {s_q.vbase, src, 1'b0};
  end
  assign IRQ = rx_err_irq || adr_irq || rx_dat_irq || tx_irq;
  // DMA requests ignore the data masks, receive first
  assign RX_DMA_REQ = s_q.ctrl[CTL_RXDMA] && s_q.flags[FLG_DAT];
  assign TX_DMA_REQ = s_q.ctrl[CTL_TXDMA] && s_q.flags[FLG_TBE] &&
    !RX_DMA_REQ;
  assign wsel = WR && (ADDR == ADDR_HOLDING);
  assign rsel = RD && (ADDR == ADDR_HOLDING);
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    // Divider restarts on a load so the start bit lasts a whole bit time
    s_d.bdiv = (bit_en || sh_load) ? RST_BYTE : s_q.bdiv + 8'h01;
    // Software writes
    if (WR) begin
      unique case (ADDR)
        ADDR_RX_CNT_PTR: s_d.rcp = WDATA;
        ADDR_RX_ADR_PTR: s_d.rap = WDATA;
        ADDR_TX_CNT_PTR: s_d.tcp = WDATA;
        ADDR_TX_ADR_PTR: s_d.tap = WDATA;
        ADDR_VECTOR: s_d.vbase = WDATA[7:3];
        ADDR_MATCH: s_d.cmp = WDATA;
        ADDR_MASK: begin
          s_d.mask = WDATA;
          // End-of-block bits only clear from software
          s_d.mask[MSK_RX_BLOCK_DONE] = s_q.mask[MSK_RX_BLOCK_DONE] & WDATA[MSK_RX_BLOCK_DONE];
          s_d.mask[MSK_TX_BLOCK_DONE] = s_q.mask[MSK_TX_BLOCK_DONE] & WDATA[MSK_TX_BLOCK_DONE];
        end
        ADDR_FLAGS: s_d.flags = s_q.flags & WDATA;
        ADDR_HOLDING: begin
          s_d.txbuf = WDATA;
          s_d.txfull = 1'b1;
        end
        ADDR_CTRL: s_d.ctrl = WDATA;
        default: ;
      endcase
    end
    // Transmit side
    if (sh_load) begin
      s_d.txfull = wsel;
    end
    s_d.flags[FLG_TBE] = s_d.flags[FLG_TBE] | !s_d.txfull;
    if (sh_done && !s_d.txfull) begin
      s_d.flags[FLG_TSE] = 1'b1;
    end
    if (wsel) begin
      s_d.flags[FLG_TSE] = 1'b0;
    end
    // Receive side: hardware sets win over software clears
    if (RX_BREAK) begin
      s_d.flags[FLG_BRK] = 1'b1;
    end
    // A read of the receive buffer marks the word as taken
    if (rsel) begin
      s_d.rxunread = 1'b0;
    end
    if (RX_WORD) begin
      if (RX_FRAME_ERR) begin
        s_d.flags[FLG_FRM] = 1'b1;
      end
      if (RX_PARITY_ERR) begin
        s_d.flags[FLG_PAR] = 1'b1;
      end
      if (s_q.ctrl[CTL_ADRMODE] && rx_hit && !RX_FRAME_ERR) begin
        s_d.flags[FLG_ADR] = 1'b1;
        s_d.addressed = 1'b1;
      end else if (!s_q.ctrl[CTL_ADRMODE] || s_q.addressed || RX_FRAME_ERR) begin
        s_d.rxbuf = rx_word;
        s_d.flags[FLG_DAT] = 1'b1;
        if (s_q.rxunread && !rsel) begin
          s_d.flags[FLG_OVR] = 1'b1;
        end
        s_d.rxunread = 1'b1;
      end
    end
    if (!s_q.ctrl[CTL_ADRMODE]) begin
      s_d.addressed = 1'b0;
    end
    // Block end clears DMA enable and flags end of block
    if (RX_DMA_EOB) begin
      s_d.ctrl[CTL_RXDMA] = 1'b0;
      s_d.mask[MSK_RX_BLOCK_DONE] = 1'b1;
    end
    if (TX_DMA_EOB) begin
      s_d.ctrl[CTL_TXDMA] = 1'b0;
      s_d.mask[MSK_TX_BLOCK_DONE] = 1'b1;
    end
    // Read data, one cycle later; unmapped reads zero
    s_d.rdata = RST_BYTE;
    if (RD) begin
      unique case (ADDR)
        ADDR_RX_CNT_PTR: s_d.rdata = s_q.rcp;
        ADDR_RX_ADR_PTR: s_d.rdata = s_q.rap;
        ADDR_TX_CNT_PTR: s_d.rdata = s_q.tcp;
        ADDR_TX_ADR_PTR: s_d.rdata = s_q.tap;
        ADDR_VECTOR: s_d.rdata = vec_rd;
        ADDR_MATCH: s_d.rdata = s_q.cmp;
        ADDR_MASK: s_d.rdata = s_q.mask;
        ADDR_FLAGS: s_d.rdata = s_q.flags;
        ADDR_HOLDING: s_d.rdata = s_q.rxbuf;
        ADDR_CTRL: s_d.rdata = s_q.ctrl;
        default: s_d.rdata = RST_BYTE;
      endcase
    end
  end
  // State register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '{RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE, 5'h00, RST_BYTE, RST_BYTE,
        RST_FLAGS, RST_BYTE, ALL_ONES, RST_BYTE, 1'b0, 1'b0, 1'b0, RST_BYTE, RST_BYTE};
    end else begin
      s_q <= s_d;
    end
  end
  assign RDATA = s_q.rdata;
  // ****************************************
  // Checks
  // ****************************************
  a_vec_zero_bit: assert property (@(posedge MCLK) disable iff (!RST_N)
    RD && ADDR == ADDR_VECTOR |=> !RDATA[0]) else $error("vector bit 0 not zero");
  a_flag_no_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    WR && ADDR == ADDR_FLAGS && !WDATA[FLG_BRK] && !RX_BREAK |=> !s_q.flags[FLG_BRK])
    else $error("flag write failed to clear");
  a_rx_block_done_sticky: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_q.mask[MSK_RX_BLOCK_DONE] && !(WR && ADDR == ADDR_MASK) |=> s_q.mask[MSK_RX_BLOCK_DONE])
    else $error("rx end of block dropped");
  a_tx_block_done_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    TX_DMA_EOB |=> s_q.mask[MSK_TX_BLOCK_DONE] && !s_q.ctrl[CTL_TXDMA])
    else $error("tx end of block not set");
  a_overrun_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    RX_WORD && !s_q.ctrl[CTL_ADRMODE] && s_q.rxunread && !rsel
    |=> s_q.flags[FLG_OVR]) else $error("overrun missed");
  a_break_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    RX_BREAK |=> s_q.flags[FLG_BRK]) else $error("break missed");
  a_err_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
    !s_q.mask[MSK_RXERR] |-> !rx_err_irq) else $error("masked error request");
  a_rxdma_prio: assert property (@(posedge MCLK) disable iff (!RST_N)
    RX_DMA_REQ |-> !TX_DMA_REQ) else $error("dma priority broken");
  a_data_load: assert property (@(posedge MCLK) disable iff (!RST_N)
    RX_WORD && !s_q.ctrl[CTL_ADRMODE] |=> s_q.rxbuf == $past(rx_word))
    else $error("buffer not loaded");
  // Receive flags follow their events
  a_frame_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    RX_WORD && RX_FRAME_ERR |=> s_q.flags[FLG_FRM])
    else $error("framing flag missed");
  a_parity_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    RX_WORD && RX_PARITY_ERR |=> s_q.flags[FLG_PAR])
    else $error("parity flag missed");
  a_data_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
    RX_WORD && !s_q.ctrl[CTL_ADRMODE] |=> s_q.flags[FLG_DAT])
    else $error("data flag missed");
  // Addressed modes: match flag, then words stored
  a_match_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    RX_WORD && s_q.ctrl[CTL_ADRMODE] && rx_hit && !RX_FRAME_ERR |=> s_q.flags[FLG_ADR])
    else $error("address match missed");
  a_addr_store: assert property (@(posedge MCLK) disable iff (!RST_N)
    RX_WORD && s_q.ctrl[CTL_ADRMODE] && s_q.addressed && !rx_hit
    |=> s_q.rxbuf == $past(rx_word)) else $error("addressed word not stored");
  // Transmit side: buffer empty flag, load and shifter empty
  a_tbe_empty: assert property (@(posedge MCLK) disable iff (!RST_N)
    !s_q.txfull |-> s_q.flags[FLG_TBE]) else $error("buffer empty flag low while empty");
  a_tx_load: assert property (@(posedge MCLK) disable iff (!RST_N)
    sh_load && !wsel |=> !s_q.txfull && sh_busy)
    else $error("holding byte not moved to shifter");
  a_tse_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    sh_done && !s_q.txfull && !wsel |=> s_q.flags[FLG_TSE])
    else $error("shifter empty flag missed");
  // End of block, DMA substitution and vector contents
  a_rx_block_done_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    RX_DMA_EOB |=> s_q.mask[MSK_RX_BLOCK_DONE] && !s_q.ctrl[CTL_RXDMA])
    else $error("rx end of block not set");
  a_rx_block_done_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    WR && ADDR == ADDR_MASK && !WDATA[MSK_RX_BLOCK_DONE] && !RX_DMA_EOB |=> !s_q.mask[MSK_RX_BLOCK_DONE])
    else $error("rx end of block not cleared");
  a_dma_sub: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_q.ctrl[CTL_RXDMA] && !s_q.mask[MSK_RX_BLOCK_DONE] |-> !rx_dat_irq)
    else $error("data request while rx dma runs");
  a_err_vector: assert property (@(posedge MCLK) disable iff (!RST_N)
    RD && ADDR == ADDR_VECTOR && rx_err_irq |=> RDATA[2:1] == SRC_RXERR)
    else $error("vector code not receive error");
  a_vec_base: assert property (@(posedge MCLK) disable iff (!RST_N)
    RD && ADDR == ADDR_VECTOR |=> RDATA[7:3] == $past(s_q.vbase))
    else $error("vector base not returned");
  // ****************************************
  // Coverage
  // ****************************************
  // Main scenarios reached
  c_tx_load: cover property (@(posedge MCLK) disable iff (!RST_N) sh_load);
  c_addr_hit: cover property (@(posedge MCLK) disable iff (!RST_N) s_d.flags[FLG_ADR]);
  c_rx_eob: cover property (@(posedge MCLK) disable iff (!RST_N) RX_DMA_EOB);
  c_tx_done: cover property (@(posedge MCLK) disable iff (!RST_N) sh_done);
  c_overrun: cover property (@(posedge MCLK) disable iff (!RST_N) s_q.flags[FLG_OVR]);
endmodule
`default_nettype wire

// ---- rtl/sprdr_pkg.sv ----
/*
  Constants for the serial port interrupt and DMA register block.
  Assumes an 8-bit register port with byte offsets as listed here.
*/
`default_nettype none
package sprdr_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_RX_CNT_PTR = 8'hF0;
  localparam logic [7:0] ADDR_RX_ADR_PTR = 8'hF1;
  localparam logic [7:0] ADDR_TX_CNT_PTR = 8'hF2;
  localparam logic [7:0] ADDR_TX_ADR_PTR = 8'hF3;
  localparam logic [7:0] ADDR_VECTOR = 8'hF4;
  localparam logic [7:0] ADDR_MATCH = 8'hF5;
  localparam logic [7:0] ADDR_MASK = 8'hF6;
  localparam logic [7:0] ADDR_FLAGS = 8'hF7;
  localparam logic [7:0] ADDR_HOLDING = 8'hF8;
  localparam logic [7:0] ADDR_CTRL = 8'hF9;
  // ****************************************
  // Mask register fields
  // ****************************************
  localparam int MSK_TXSRC = 7;
  localparam int MSK_RX_BLOCK_DONE = 6;
  localparam int MSK_TX_BLOCK_DONE = 5;
  localparam int MSK_RXERR = 4;
  localparam int MSK_ADDR = 3;
  localparam int MSK_BRK = 2;
  localparam int MSK_RX_DATA_IRQ_ENABLE = 1;
  localparam int MSK_TX_DATA_IRQ_ENABLE = 0;
  // ****************************************
  // Status register fields
  // ****************************************
  localparam int FLG_OVR = 7;
  localparam int FLG_FRM = 6;
  localparam int FLG_PAR = 5;
  localparam int FLG_ADR = 4;
  localparam int FLG_BRK = 3;
  localparam int FLG_DAT = 2;
  localparam int FLG_TBE = 1;
  localparam int FLG_TSE = 0;
  // ****************************************
  // Control register fields (rx dma, tx dma, addressed mode)
  // ****************************************
  localparam int CTL_RXDMA = 4;
  localparam int CTL_TXDMA = 3;
  localparam int CTL_ADRMODE = 0;
  // ****************************************
  // Vector source codes and reset values
  // ****************************************
  localparam logic [1:0] SRC_RXERR = 2'h0;
  localparam logic [1:0] SRC_ADRBRK = 2'h1;
  localparam logic [1:0] SRC_RXDATA = 2'h2;
  localparam logic [1:0] SRC_TXEMPTY = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h03;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  typedef enum logic [1:0] {SPRDR_TX_IDLE, SPRDR_TX_BUSY} sprdr_txst_t;
endpackage
`default_nettype wire

// ---- rtl/sprdr_rxfmt.sv ----
/*
  Receive word formatter: pads short characters with ones, checks the match.
  Assumes word length code 0..3 meaning 5..8 data bits.
*/
`default_nettype none
module sprdr_rxfmt
  import sprdr_pkg::*;
(
  // Raw word
  input wire logic [7:0] raw,
  input wire logic [1:0] wlen,
  input wire logic [7:0] cmp,
  // Result
  output logic [7:0] word,
  output logic hit
);
  // Unused upper bits read as one
  always_comb begin
    word = raw;
    for (int i = 5; i < 8; i++) begin
      if (i > 32'(wlen) + 4) begin
        word[i] = 1'b1;
      end
    end
    hit = (word == cmp);
  end
endmodule
`default_nettype wire

// ---- rtl/sprdr_txshift.sv ----
/*
  Transmit shift timing stand-in: holds a loaded byte for a word time.
  Assumes one-cycle bit enable from the parent's divider.
*/
`default_nettype none
module sprdr_txshift
  import sprdr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Load side
  input wire logic bit_en,
  input wire logic load,
  input wire logic [7:0] data,
  // Status
  output logic busy,
  output logic done,
  output logic serial
);
  typedef struct packed {
    sprdr_txst_t st;
    logic [9:0] sh;
    logic [3:0] cnt;
    logic done;
  } sprdr_ts_t;
  localparam logic [3:0] WORD_BITS = 4'hA;
  sprdr_ts_t s_q, s_d;
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      SPRDR_TX_IDLE: begin
        if (load) begin
          s_d.st = SPRDR_TX_BUSY;
          s_d.sh = {1'b1, data, 1'b0};
          s_d.cnt = WORD_BITS;
        end
      end
      SPRDR_TX_BUSY: begin
        if (bit_en) begin
          s_d.sh = {1'b1, s_q.sh[9:1]};
          s_d.cnt = s_q.cnt - 4'h1;
          if (s_q.cnt == 4'h1) begin
            s_d.st = SPRDR_TX_IDLE;
            s_d.done = 1'b1;
          end
        end
      end
      default: s_d.st = SPRDR_TX_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{SPRDR_TX_IDLE, 10'h3FF, 4'h0, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
  assign busy = (s_q.st == SPRDR_TX_BUSY);
  assign done = s_q.done;
  assign serial = s_q.sh[0];
endmodule
`default_nettype wire

// ---- verif/sprdr_station.sv ----
/*
  Remote station model: hands finished words and breaks to the block.
  Assumes the bench calls its tasks from one process.
*/
`default_nettype none
module sprdr_station
  import sprdr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Received word side
  output logic word,
  output logic [7:0] raw,
  output logic [1:0] wlen,
  output logic ferr,
  output logic perr,
  output logic brk
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Word delivery
  // ********
  // Idle lines at time zero
  initial begin
    word = 1'b0;
    raw = 8'h00;
    wlen = 2'h3;
    ferr = 1'b0;
    perr = 1'b0;
    brk = 1'b0;
  end
  // One-cycle strobe; data idles at inverse so nothing stale looks valid
  task automatic send(input logic [7:0] d, input logic [1:0] wl, input logic fe,
                      input logic pe);
    @(posedge clk);
    word <= 1'b1;
    raw <= d;
    wlen <= wl;
    ferr <= fe;
    perr <= pe;
    @(posedge clk);
    word <= 1'b0;
    raw <= ~d;
    ferr <= 1'b0;
    perr <= 1'b0;
  endtask
  // Break strobe held for one clock cycle
  task automatic line_break();
    @(posedge clk);
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/test_sprdr_top.sv ----
/*
  Self-checking bench for the serial port interrupt and DMA registers.
  Assumes the station model drives the receiver word inputs.
*/
`default_nettype none
module test_sprdr_top
  import sprdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Signals and instances
  // ********
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic RX_DMA_EOB = 1'b0;
  logic TX_DMA_EOB = 1'b0;
  logic [7:0] RDATA, RX_RAW;
  logic [1:0] RX_WLEN;
  logic RX_WORD, RX_FRAME_ERR, RX_PARITY_ERR, RX_BREAK;
  logic RX_DMA_REQ, TX_DMA_REQ, IRQ, TXD_OUT;
  int failures = 0;
  int compares = 0;
  // Clock of 4 ns
  always #2 MCLK = ~MCLK;
  sprdr_top sprdr_top_inst (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .RX_WORD(RX_WORD), .RX_RAW(RX_RAW),
    .RX_WLEN(RX_WLEN), .RX_FRAME_ERR(RX_FRAME_ERR), .RX_PARITY_ERR(RX_PARITY_ERR),
    .RX_BREAK(RX_BREAK), .RX_DMA_EOB(RX_DMA_EOB), .TX_DMA_EOB(TX_DMA_EOB),
    .RX_DMA_REQ(RX_DMA_REQ), .TX_DMA_REQ(TX_DMA_REQ), .IRQ(IRQ), .TXD_OUT(TXD_OUT));
  sprdr_station sprdr_station_inst (.clk(MCLK), .word(RX_WORD), .raw(RX_RAW),
    .wlen(RX_WLEN), .ferr(RX_FRAME_ERR), .perr(RX_PARITY_ERR), .brk(RX_BREAK));
  // ********
  // Bus and compare tasks
  // ********
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, e);
  endtask
  task automatic irq(input logic e);
    #1;
    chk({7'h00, IRQ}, {7'h00, e});
  endtask
  task automatic bit_at(input int c, input logic e);
    repeat (c) @(posedge MCLK);
    #1;
    chk({7'h00, TXD_OUT}, {7'h00, e});
  endtask
  task automatic finish_test();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      wr(i == 4 ? 8'hF5 : 8'hF0 + i[7:0], 8'h3C ^ (8'h11 * i[7:0]));
    end
    for (int i = 0; i < 5; i++) begin
      rd(i == 4 ? 8'hF5 : 8'hF0 + i[7:0], 8'h3C ^ (8'h11 * i[7:0]));
    end
    wr(8'hE0, 8'hFF);
    rd(8'hE0, 8'h00);
    rd(8'hF0, 8'h3C);
    wr(8'hF4, 8'hFF);
    rd(8'hF4, 8'hFE);
    wr(8'hF4, 8'h00);
    rd(8'hF4, 8'h06);
  endtask
  task automatic t_rx();
    wr(8'hF7, 8'hFC);
    wr(8'hF7, 8'hFF);
    rd(8'hF7, 8'h02);
    wr(8'hF6, 8'h1F);
    irq(1'b0);
    sprdr_station_inst.send(8'h3C, 2'h1, 1'b0, 1'b0);
    rd(8'hF7, 8'h06);
    irq(1'b1);
    rd(8'hF8, 8'hFC);
    sprdr_station_inst.send(8'h81, 2'h3, 1'b0, 1'b0);
    sprdr_station_inst.send(8'h05, 2'h0, 1'b0, 1'b0);
    rd(8'hF7, 8'h86);
    rd(8'hF4, 8'h00);
    rd(8'hF8, 8'hE5);
    wr(8'hF7, 8'h7F);
    rd(8'hF7, 8'h06);
    wr(8'hF6, 8'h1D);
    irq(1'b0);
  endtask
  // Kind 0 framing, 1 parity, 2 break
  task automatic t_err(input int k, input logic [7:0] fl, input logic [7:0] m,
                       input logic [7:0] v);
    wr(8'hF7, 8'h00);
    wr(8'hF6, 8'h00);
    if (k == 2) begin
      sprdr_station_inst.line_break();
    end else begin
      sprdr_station_inst.send(8'h00, 2'h3, k == 0, k == 1);
    end
    rd(8'hF7, fl);
    irq(1'b0);
    wr(8'hF6, m);
    irq(1'b1);
    rd(8'hF4, v);
    rd(8'hF8, 8'h00);
  endtask
  task automatic t_addr();
    wr(8'hF7, 8'h00);
    wr(8'hF6, 8'h00);
    wr(8'hF9, 8'h01);
    wr(8'hF5, 8'h55);
    sprdr_station_inst.send(8'h12, 2'h3, 1'b0, 1'b0);
    rd(8'hF7, 8'h02);
    sprdr_station_inst.send(8'h55, 2'h3, 1'b0, 1'b0);
    rd(8'hF7, 8'h12);
    wr(8'hF6, 8'h08);
    irq(1'b1);
    rd(8'hF4, 8'h02);
    sprdr_station_inst.send(8'h66, 2'h3, 1'b0, 1'b0);
    rd(8'hF7, 8'h16);
    rd(8'hF8, 8'h66);
    wr(8'hF9, 8'h00);
  endtask
  task automatic t_tx();
    int n;
    logic [7:0] b;
    n = 0;
    b = 8'hA5;
    wr(8'hF7, 8'h00);
    wr(8'hF6, 8'h01);
    irq(1'b0);
    wr(8'hF6, 8'h81);
    irq(1'b1);
    wr(8'hF8, b);
    while (TXD_OUT !== 1'b0 && n < 40) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    irq(1'b1);
    bit_at(8, 1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_at(16, b[i]);
    end
    bit_at(16, 1'b1);
    repeat (16) @(posedge MCLK);
    rd(8'hF7, 8'h03);
    wr(8'hF6, 8'h01);
    irq(1'b1);
    wr(8'hF7, 8'hFE);
    irq(1'b0);
    wr(8'hF6, 8'h81);
    irq(1'b1);
  endtask
  task automatic t_dma(input logic tx);
    logic [7:0] e;
    e = tx ? 8'h20 : 8'h40;
    wr(8'hF7, 8'h00);
    wr(8'hF6, 8'h00);
    wr(8'hF9, tx ? 8'h08 : 8'h10);
    #1;
    if (!tx) begin
      sprdr_station_inst.send(8'h11, 2'h3, 1'b0, 1'b0);
      #1;
      chk({7'h00, RX_DMA_REQ}, 8'h01);
      // Data mask set: pending data raises no interrupt while DMA runs
      wr(8'hF6, 8'h02);
      irq(1'b0);
      chk({7'h00, RX_DMA_REQ}, 8'h01);
      wr(8'hF6, 8'h00);
    end else begin
      chk({7'h00, TX_DMA_REQ}, 8'h01);
    end
    @(posedge MCLK);
    RX_DMA_EOB <= !tx;
    TX_DMA_EOB <= tx;
    @(posedge MCLK);
    RX_DMA_EOB <= 1'b0;
    TX_DMA_EOB <= 1'b0;
    rd(8'hF6, e);
    rd(8'hF9, 8'h00);
    chk({6'h00, RX_DMA_REQ, TX_DMA_REQ}, 8'h00);
    wr(8'hF7, 8'h00);
    irq(1'b0);
    wr(8'hF6, e | (tx ? 8'h01 : 8'h02));
    irq(1'b1);
    rd(8'hF4, tx ? 8'h06 : 8'h04);
    wr(8'hF6, 8'h00);
    wr(8'hF6, e);
    rd(8'hF6, 8'h00);
  endtask
  // ********
  // Main sequence and watchdog
  // ********
  initial begin
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    rd(8'hF7, 8'h03);
    rd(8'hF8, 8'hFF);
    rd(8'hF6, 8'h00);
    irq(1'b0);
    t_regs();
    t_rx();
    t_err(0, 8'h46, 8'h10, 8'h00);
    t_err(1, 8'h26, 8'h10, 8'h00);
    t_err(2, 8'h0A, 8'h04, 8'h02);
    t_addr();
    t_tx();
    t_dma(1'b0);
    t_dma(1'b1);
    finish_test();
  end
  initial begin
    #40000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
